/* File: src/cbi_consts.vh */
// Constants for the parallel host port of the time-slot switch
// How it works
// RULE_01: Serial bit clock runs at 4.096 or 8.192 MHz per speed select.
// RULE_02: Serial clock edges time every bit shifted on the serial streams.
// RULE_03: Non-multiplexed bus takes six shared pins as address bits 0 to 5.
// RULE_04: In 16x8 mode first three shared pins are slow serial inputs 8-10.
// RULE_05: In 16x8 mode next three shared pins are slow serial inputs 11-13.
// RULE_06: Strobe pin is active-high data strobe, qualified by low chip select.
// RULE_07: In separate-strobe mode strobe pin is active-low read, drives data.
// RULE_08: Direction pin picks read or write in strobe-style modes.
// RULE_09: In separate-strobe mode direction pin is active-low write strobe.
// RULE_10: No access happens unless the active-low chip select is asserted.
// RULE_11: Data lines carry control register and memory page accesses.
// RULE_12: In multiplexed mode the address arrives on the data lines.
// RULE_13: Multiplex select pin high picks multiplexed bus, low the direct one.
// RULE_14: Address latch samples data lines on falling address strobe edge.
// RULE_15: Open-drain acknowledge pulled low when a transfer has completed.
// RULE_16: Address decode picks control register or selected memory page.
`ifndef CBI_CONSTS_VH
`define CBI_CONSTS_VH

// Bus widths
`define CBI_DATA_W 8
`define CBI_ADDR_W 8
`define CBI_CHAN_W 5
`define CBI_PAGE_W 2

// Address bit that separates control register from memory pages
`define CBI_ADDR_MEM_BIT 5

// Control register layout and reset value
`define CBI_CTRL_RESET 8'h00
`define CBI_CTRL_PAGE_LSB 3
`define CBI_CTRL_PAGE_MSB 4

// Memory page codes held in the control register page field
`define CBI_PAGE_DATA 2'h0
`define CBI_PAGE_CONN_LOW 2'h2
`define CBI_PAGE_CONN_HIGH 2'h3

// Serial clock rates in kHz and the slow stream bit rate in kb/s
`define CBI_SCLK_SLOW_KHZ 4096
`define CBI_SCLK_FAST_KHZ 8192
`define CBI_LOW_RATE_KBPS 2048
// Serial clock edges per slow stream bit, derived from the rates
`define CBI_DIV_SLOW (`CBI_SCLK_SLOW_KHZ / `CBI_LOW_RATE_KBPS)
`define CBI_DIV_FAST (`CBI_SCLK_FAST_KHZ / `CBI_LOW_RATE_KBPS)

// Bits per serial byte
`define CBI_BITS_PER_BYTE 8

`endif

/* File: src/cbi_strobe_decode.v */
// Read and write access qualifier for the shared strobe pins
`timescale 1ns/10ps
module cbi_strobe_decode (
    input wire sep_strobe_mode_in,
    input wire cs_n_in,
    input wire strobe_or_read_pin_in,
    input wire dir_or_write_pin_in,
    output reg rd_active_out,
    output reg wr_active_out
);

    // Pin meaning follows the bus style; chip select gates both
    always @* begin
        rd_active_out = 1'b0;
        wr_active_out = 1'b0;
        if (!cs_n_in) begin // [RULE_10]
            if (sep_strobe_mode_in) begin
                // Active-low read and write strobes
                rd_active_out = !strobe_or_read_pin_in; // [RULE_07]
                wr_active_out = !dir_or_write_pin_in && strobe_or_read_pin_in; // [RULE_09]
            end else if (strobe_or_read_pin_in) begin // [RULE_06]
                // Direction pin high reads, low writes
                rd_active_out = dir_or_write_pin_in; // [RULE_08]
                wr_active_out = !dir_or_write_pin_in; // [RULE_08]
            end
        end
    end

endmodule // cbi_strobe_decode

/* File: src/cbi_serial_deser.v */
// Slow-rate serial input deserialiser for a group of streams
`timescale 1ns/10ps
`include "cbi_consts.vh"
module cbi_serial_deser #(
    parameter STREAMS = 3
) (
    input wire sys_clk_in,
    input wire rst_in,
    input wire enable_in,
    input wire bit_tick_in,
    input wire [STREAMS-1:0] serial_in,
    output reg [STREAMS*8-1:0] bytes_out,
    output reg valid_out
);

    reg [STREAMS*8-1:0] shift_q;
    reg [2:0] bit_cnt_q;
    integer i;

    // Shift one bit per tick, MSB first; publish every eighth bit
    always @(posedge sys_clk_in) begin
        if (rst_in || !enable_in) begin
            shift_q <= {STREAMS*8{1'b0}};
            bit_cnt_q <= 3'h0;
            bytes_out <= {STREAMS*8{1'b0}};
            valid_out <= 1'b0;
        end else begin
            valid_out <= 1'b0;
            if (bit_tick_in) begin
                for (i = 0; i < STREAMS; i = i + 1) begin
                    shift_q[i*8 +: 8] <= {shift_q[i*8 +: 7], serial_in[i]};
                end
                bit_cnt_q <= bit_cnt_q + 3'h1;
                if (bit_cnt_q == 3'h7) begin
                    for (i = 0; i < STREAMS; i = i + 1) begin
                        bytes_out[i*8 +: 8] <= {shift_q[i*8 +: 7],
                            serial_in[i]};
                    end
                    valid_out <= 1'b1;
                end
            end
        end
    end

endmodule // cbi_serial_deser

/* File: src/cbi_host_port.v */
// Parallel host port with address latch, decode and slow serial inputs
`timescale 1ns/10ps
`include "cbi_consts.vh"
module cbi_host_port (
    input wire sys_clk_in,
    input wire rst_in,
    // Bus style pins
    input wire bus_multiplex_select_in,
    input wire sep_strobe_style_in,
    input wire switch_16x8_in,
    input wire serial_speed_select_reg_in,
    // Host bus
    input wire cs_n_in,
    input wire strobe_or_read_pin_in,
    input wire dir_or_write_pin_in,
    input wire address_latch_strobe_in,
    input wire [2:0] low_addr_or_serial_in_a_in,
    input wire [2:0] mid_addr_or_serial_in_b_in,
    input wire [7:0] cpu_data_lines_in,
    output reg [7:0] cpu_data_lines_out,
    output wire cpu_data_lines_oe_out,
    output wire transfer_ack_n_out,
    output wire transfer_ack_n_oe_out,
    // Serial clock
    input wire serial_clk_in,
    output wire serial_bit_tick_out,
    output wire [47:0] serial_in_bytes_out,
    output wire serial_in_valid_out,
    // Switching core side
    output reg [7:0] ctrl_reg_out,
    output reg mem_req_out,
    output reg mem_we_out,
    output reg [1:0] mem_page_out,
    output reg [4:0] mem_addr_out,
    output reg [7:0] mem_wdata_out,
    input wire [7:0] mem_rdata_in,
    input wire mem_ack_in
);

    // Access states
    localparam ST_IDLE = 2'h0;
    localparam ST_WAIT = 2'h1;
    localparam ST_ACK = 2'h2;

    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [7:0] addr_latch_q;
    reg ale_prev_q;
    reg sclk_prev_q;
    reg [1:0] div_cnt_q;
    reg bit_tick_q;
    wire rd_active;
    wire wr_active;
    wire access_active;
    wire sep_strobe_mode;
    wire sclk_rise;
    wire [1:0] div_last;
    wire [7:0] direct_addr;
    wire [7:0] eff_addr;
    wire addr_is_mem;

    // Separate strobes exist only on the multiplexed bus
    assign sep_strobe_mode = bus_multiplex_select_in && sep_strobe_style_in;

    cbi_strobe_decode u_strobe (
        .sep_strobe_mode_in(sep_strobe_mode),
        .cs_n_in(cs_n_in),
        .strobe_or_read_pin_in(strobe_or_read_pin_in),
        .dir_or_write_pin_in(dir_or_write_pin_in),
        .rd_active_out(rd_active),
        .wr_active_out(wr_active)
    );

    assign access_active = rd_active || wr_active;

    // Address source: latch on the multiplexed bus, pins otherwise
    assign direct_addr = {2'h0, mid_addr_or_serial_in_b_in,
        low_addr_or_serial_in_a_in}; // [RULE_03]
    assign eff_addr = bus_multiplex_select_in ? addr_latch_q
        : direct_addr; // [RULE_13]

    // One address bit splits control register from memory pages
    function is_mem_addr;
        input [7:0] a;
        begin
            is_mem_addr = a[`CBI_ADDR_MEM_BIT];
        end
    endfunction

    assign addr_is_mem = is_mem_addr(eff_addr); // [RULE_16]

    // Address strobe falling edge captures the multiplexed address
    always @(posedge sys_clk_in) begin
        if (rst_in) begin
            ale_prev_q <= 1'b0;
            addr_latch_q <= 8'h00;
        end else begin
            ale_prev_q <= address_latch_strobe_in;
            if (bus_multiplex_select_in && ale_prev_q
                && !address_latch_strobe_in) begin // [RULE_14]
                addr_latch_q <= cpu_data_lines_in; // [RULE_12]
            end
        end
    end

    // Serial clock is sampled; its rising edge times every bit
    always @(posedge sys_clk_in) begin
        if (rst_in) begin
            sclk_prev_q <= 1'b0;
        end else begin
            sclk_prev_q <= serial_clk_in;
        end
    end

    assign sclk_rise = serial_clk_in && !sclk_prev_q; // [RULE_02]

    // Divider end points, cut to the counter width on purpose
    wire [31:0] div_fast_last = `CBI_DIV_FAST - 1;
    wire [31:0] div_slow_last = `CBI_DIV_SLOW - 1;

    // Divider length follows the host-selected serial clock rate
    assign div_last = serial_speed_select_reg_in
        ? div_fast_last[1:0] : div_slow_last[1:0]; // [RULE_01]

    // Slow stream bit tick; only serial clock edges advance it
    always @(posedge sys_clk_in) begin
        if (rst_in) begin
            div_cnt_q <= 2'h0;
            bit_tick_q <= 1'b0;
        end else begin
            bit_tick_q <= 1'b0;
            if (sclk_rise) begin // [RULE_02]
                if (div_cnt_q >= div_last) begin
                    div_cnt_q <= 2'h0;
                    bit_tick_q <= 1'b1;
                end else begin
                    div_cnt_q <= div_cnt_q + 2'h1;
                end
            end
        end
    end

    assign serial_bit_tick_out = bit_tick_q;

    // Shared pins become serial inputs only in the 16x8 configuration
    cbi_serial_deser #(
        .STREAMS(3)
    ) u_deser_a (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .enable_in(switch_16x8_in), // [RULE_04]
        .bit_tick_in(bit_tick_q),
        .serial_in(low_addr_or_serial_in_a_in),
        .bytes_out(serial_in_bytes_out[23:0]),
        .valid_out(serial_in_valid_out)
    );

    cbi_serial_deser #(
        .STREAMS(3)
    ) u_deser_b (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .enable_in(switch_16x8_in), // [RULE_05]
        .bit_tick_in(bit_tick_q),
        .serial_in(mid_addr_or_serial_in_b_in),
        .bytes_out(serial_in_bytes_out[47:24]),
        .valid_out()
    );

    // Next access state
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (access_active) begin // [RULE_10]
                    state_d = addr_is_mem ? ST_WAIT : ST_ACK;
                end
            end
            ST_WAIT: begin
                // Core must answer; the host keeps its strobe meanwhile
                if (mem_ack_in) begin
                    state_d = ST_ACK;
                end
            end
            ST_ACK: begin
                if (!access_active) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // Access sequencing, control register and read data capture
    always @(posedge sys_clk_in) begin
        if (rst_in) begin
            state_q <= ST_IDLE;
            ctrl_reg_out <= `CBI_CTRL_RESET;
            mem_req_out <= 1'b0;
            mem_we_out <= 1'b0;
            mem_page_out <= `CBI_PAGE_DATA;
            mem_addr_out <= 5'h00;
            mem_wdata_out <= 8'h00;
            cpu_data_lines_out <= 8'h00;
        end else begin
            state_q <= state_d;
            mem_req_out <= 1'b0;
            if (state_q == ST_IDLE && access_active) begin
                if (addr_is_mem) begin
                    // Page comes from the control register field
                    mem_req_out <= 1'b1; // [RULE_16]
                    mem_we_out <= wr_active;
                    mem_page_out <= ctrl_reg_out[`CBI_CTRL_PAGE_MSB:
                        `CBI_CTRL_PAGE_LSB];
                    mem_addr_out <= eff_addr[4:0];
                    mem_wdata_out <= cpu_data_lines_in; // [RULE_11]
                end else begin
                    if (wr_active) begin
                        ctrl_reg_out <= cpu_data_lines_in; // [RULE_11]
                    end
                    // Old value; a same-access write shows next time
                    cpu_data_lines_out <= ctrl_reg_out;
                end
            end
            if (state_q == ST_WAIT && mem_ack_in) begin
                // Loaded with the ack so the host takes both at once
                cpu_data_lines_out <= mem_rdata_in; // [RULE_11]
            end
        end
    end

    // Drive data only during a read; write data held off the pins
    assign cpu_data_lines_oe_out = rd_active; // [RULE_07]

    // Open drain: pull low while the transfer stands completed
    assign transfer_ack_n_out = 1'b0;
    assign transfer_ack_n_oe_out = (state_q == ST_ACK); // [RULE_15]

endmodule // cbi_host_port

/* File: verification/cbi_host_port_chk.sv */
// Checker for host port strobes, data direction and acknowledge
`timescale 1ns/10ps
module cbi_host_port_chk (
    input wire sys_clk_in,
    input wire rst_in,
    input wire bus_multiplex_select_in,
    input wire sep_strobe_style_in,
    input wire cs_n_in,
    input wire strobe_or_read_pin_in,
    input wire dir_or_write_pin_in,
    input wire cpu_data_lines_oe_out,
    input wire transfer_ack_n_out,
    input wire transfer_ack_n_oe_out,
    input wire mem_req_out,
    input wire [1:0] mem_page_out,
    input wire [7:0] ctrl_reg_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    // Short views; separate strobes exist only on the multiplexed bus
    wire sep = bus_multiplex_select_in && sep_strobe_style_in;
    wire cs = !cs_n_in;
    wire stb = strobe_or_read_pin_in;
    wire rw = dir_or_write_pin_in;
    wire oe = cpu_data_lines_oe_out;
    wire ack = transfer_ack_n_oe_out;
    property p_sel; $past(cs_n_in) |-> !mem_req_out; endproperty
    a_sel: assert property (p_sel) else $error("unselected req");
    property p_dir; !sep && cs && stb |-> oe == rw; endproperty
    a_dir: assert property (p_dir) else $error("bad dir");
    property p_rd; sep && cs && !stb |-> oe; endproperty
    a_rd: assert property (p_rd) else $error("read not driven");
    property p_wr; sep && !rw && stb |-> !oe; endproperty
    a_wr: assert property (p_wr) else $error("write driven");
    property p_lvl; transfer_ack_n_out == 1'b0; endproperty
    a_lvl: assert property (p_lvl) else $error("ack level");
    property p_rise; $rose(ack) |-> $past(cs_n_in) == 1'b0; endproperty
    a_rise: assert property (p_rise) else $error("ack unselected");
    property p_due; mem_req_out |-> ##[2:12] ack; endproperty
    a_due: assert property (p_due) else $error("ack late");
    property p_drop; ack && cs_n_in |=> !ack; endproperty
    a_drop: assert property (p_drop) else $error("ack stuck");
    property p_page;
        mem_req_out |-> mem_page_out == ctrl_reg_out[4:3];
    endproperty
    a_page: assert property (p_page) else $error("bad page");
endmodule // cbi_host_port_chk

bind cbi_host_port cbi_host_port_chk cbi_host_port_chk_inst (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .bus_multiplex_select_in(bus_multiplex_select_in),
    .sep_strobe_style_in(sep_strobe_style_in),
    .cs_n_in(cs_n_in),
    .strobe_or_read_pin_in(strobe_or_read_pin_in),
    .dir_or_write_pin_in(dir_or_write_pin_in),
    .cpu_data_lines_oe_out(cpu_data_lines_oe_out),
    .transfer_ack_n_out(transfer_ack_n_out),
    .transfer_ack_n_oe_out(transfer_ack_n_oe_out),
    .mem_req_out(mem_req_out),
    .mem_page_out(mem_page_out),
    .ctrl_reg_out(ctrl_reg_out)
);

/* File: verification/cbi_host_model.sv */
// Host processor model driving the shared bus pins
`timescale 1ns/10ps
module cbi_host_model (
    input wire clk_in,
    input wire ack_n_in,
    input wire [7:0] bus_in,
    output reg cs_n_out = 1'b1,
    output reg strobe_out = 1'b0,
    output reg dir_out = 1'b1,
    output reg als_out = 1'b0,
    output reg [5:0] addr_out = 6'h00,
    output reg [7:0] data_out = 8'h00
);
    integer timeouts = 0;
    // One access; everything holds until the acknowledge is seen, or for 8 cycles when unselected
    task xfer(input m, s, r, c, input [7:0] ad, wd, output [7:0] rv);
        integer n;
        begin
            if (m) begin
                data_out <= ad;
                als_out <= 1'b1;
                @(posedge clk_in);
                als_out <= 1'b0;
                @(posedge clk_in);
            end
            // Pins carry a wrong address on the multiplexed bus
            addr_out <= m ? ~ad[5:0] : ad[5:0];
            data_out <= wd;
            cs_n_out <= c;
            strobe_out <= s ? !r : 1'b1;
            dir_out <= r;
            n = 0;
            while (ack_n_in !== 1'b0 && n < (c ? 8 : 200)) begin
                @(posedge clk_in);
                n = n + 1;
            end
            if (!c && n >= 200) timeouts = timeouts + 1;
            // Read data stands with the acknowledge; take it, then release
            rv = bus_in;
            cs_n_out <= 1'b1;
            strobe_out <= s;
            dir_out <= 1'b1;
            data_out <= ~wd;
            repeat (2) @(posedge clk_in);
        end
    endtask
endmodule // cbi_host_model

/* File: verification/cbi_host_port_tb.sv */
// Self-checking bench for the parallel host port
`timescale 1ns/10ps
module cbi_host_port_tb;
    reg sys_clk_in = 1'b0;
    reg rst_in = 1'b1;
    reg bus_multiplex_select_in = 1'b0;
    reg sep_strobe_style_in = 1'b0;
    reg switch_16x8_in = 1'b0;
    reg serial_speed_select_reg_in = 1'b0;
    reg serial_clk_in = 1'b0;
    reg mem_ack_in = 1'b0;
    reg [7:0] mem_rdata_in = 8'h00;
    reg [5:0] sbits = 6'h00;
    wire cs_n_in, strobe_or_read_pin_in, dir_or_write_pin_in;
    wire address_latch_strobe_in, cpu_data_lines_oe_out, transfer_ack_n_out;
    wire transfer_ack_n_oe_out, serial_bit_tick_out, serial_in_valid_out;
    wire mem_req_out, mem_we_out;
    wire [5:0] h_addr;
    wire [7:0] h_data, cpu_data_lines_out, ctrl_reg_out, mem_wdata_out;
    wire [47:0] serial_in_bytes_out;
    wire [1:0] mem_page_out;
    wire [4:0] mem_addr_out;
    // Shared pins carry serial streams or address bits
    wire [2:0] low_addr_or_serial_in_a_in =
        switch_16x8_in ? sbits[2:0] : h_addr[2:0];
    wire [2:0] mid_addr_or_serial_in_b_in =
        switch_16x8_in ? sbits[5:3] : h_addr[5:3];
    wire [7:0] cpu_data_lines_in =
        cpu_data_lines_oe_out ? cpu_data_lines_out : h_data;
    wire ack_n = transfer_ack_n_oe_out ? transfer_ack_n_out : 1'b1;
    integer seed = 96;
    integer num_errors = 0;
    integer n_tests = 0;
    integer md, i, k;
    reg [7:0] cv, ad, wd, rv;
    reg [63:0] bits;
    reg [15:0] got;
    integer half = 30;
    integer sc_n = 0;

    cbi_host_port cbi_host_port_inst (.sys_clk_in(sys_clk_in),
        .rst_in(rst_in), .bus_multiplex_select_in(bus_multiplex_select_in),
        .sep_strobe_style_in(sep_strobe_style_in),
        .switch_16x8_in(switch_16x8_in),
        .serial_speed_select_reg_in(serial_speed_select_reg_in),
        .cs_n_in(cs_n_in), .strobe_or_read_pin_in(strobe_or_read_pin_in),
        .dir_or_write_pin_in(dir_or_write_pin_in),
        .address_latch_strobe_in(address_latch_strobe_in),
        .low_addr_or_serial_in_a_in(low_addr_or_serial_in_a_in),
        .mid_addr_or_serial_in_b_in(mid_addr_or_serial_in_b_in),
        .cpu_data_lines_in(cpu_data_lines_in),
        .cpu_data_lines_out(cpu_data_lines_out),
        .cpu_data_lines_oe_out(cpu_data_lines_oe_out),
        .transfer_ack_n_out(transfer_ack_n_out),
        .transfer_ack_n_oe_out(transfer_ack_n_oe_out),
        .serial_clk_in(serial_clk_in),
        .serial_bit_tick_out(serial_bit_tick_out),
        .serial_in_bytes_out(serial_in_bytes_out),
        .serial_in_valid_out(serial_in_valid_out),
        .ctrl_reg_out(ctrl_reg_out),
        .mem_req_out(mem_req_out), .mem_we_out(mem_we_out),
        .mem_page_out(mem_page_out), .mem_addr_out(mem_addr_out),
        .mem_wdata_out(mem_wdata_out), .mem_rdata_in(mem_rdata_in),
        .mem_ack_in(mem_ack_in));
    cbi_host_model cbi_host_model_inst (.clk_in(sys_clk_in), .ack_n_in(ack_n),
        .bus_in(cpu_data_lines_in), .cs_n_out(cs_n_in),
        .strobe_out(strobe_or_read_pin_in), .dir_out(dir_or_write_pin_in),
        .als_out(address_latch_strobe_in), .addr_out(h_addr),
        .data_out(h_data));

    initial forever #2 sys_clk_in = ~sys_clk_in;
    // Free-running bit clock made from the system clock so it stays
    // synchronous; half period in system cycles follows the speed
    always @(posedge sys_clk_in) begin
        if (sc_n >= half - 1) begin
            sc_n <= 0;
            serial_clk_in <= ~serial_clk_in;
        end else begin
            sc_n <= sc_n + 1;
        end
    end

    function [7:0] mdat(input [1:0] p, input [4:0] a);
        mdat = {p, a, 1'b1} ^ 8'h3c;
    endfunction

    // Core side answers each request after 0 to 3 idle cycles
    always @(posedge sys_clk_in) begin
        if (mem_req_out) begin
            got <= {mem_we_out, mem_page_out, mem_addr_out, mem_wdata_out};
            repeat ($random(seed) & 3) @(posedge sys_clk_in);
            mem_rdata_in <= mdat(mem_page_out, mem_addr_out);
            mem_ack_in <= 1'b1;
        end else begin
            mem_ack_in <= 1'b0;
        end
    end

    task chk(input string nm, input [47:0] exp, seen);
        begin
            n_tests = n_tests + 1;
            if (seen !== exp) begin
                num_errors = num_errors + 1;
                $display("mismatch %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask

    task complete_run;
        begin
            $display("comparisons %0d mismatches %0d", n_tests, num_errors);
            if (num_errors == 0 && n_tests > 0) $display("RESULT: PASS");
            else $display("RESULT: FAIL");
            $finish;
        end
    endtask

    // One host access in the current bus style; a hang ends the run
    task hx(input r, c, input [7:0] a, d);
        begin
            cbi_host_model_inst.xfer(bus_multiplex_select_in,
                sep_strobe_style_in, r, c, a, d, rv);
            if (cbi_host_model_inst.timeouts != 0) begin
                num_errors = num_errors + 1;
                complete_run;
            end
        end
    endtask

    // Bounded wait for the bit tick or the byte valid pulse
    task wt(input v);
        integer n;
        begin
            n = 0;
            while ((v ? serial_in_valid_out : serial_bit_tick_out) !== 1'b1)
            begin
                @(posedge sys_clk_in);
                n = n + 1;
                if (n > 3000) begin
                    num_errors = num_errors + 1;
                    complete_run;
                end
            end
        end
    endtask

    initial begin
        repeat (5) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        // Direct bus, data strobe multiplexed, separate strobes
        for (md = 0; md < 3; md = md + 1) begin
            @(posedge sys_clk_in);
            bus_multiplex_select_in <= md != 0;
            sep_strobe_style_in <= md == 2;
            @(posedge sys_clk_in);
            for (i = 0; i < 4; i = i + 1) begin
                cv = $random(seed);
                if (!cv[4]) cv[3] = 1'b0; // Only defined page codes
                ad = $random(seed);
                wd = $random(seed);
                hx(0, 0, {3'h0, ad[4:0]}, cv);
                chk("ctrl write", cv, ctrl_reg_out);
                hx(1, 0, {3'h0, ad[4:0]}, wd);
                chk("ctrl read", cv, rv);
                hx(0, 1, {2'h0, i[0], ad[4:0]}, ~cv);
                chk("unselected", cv, ctrl_reg_out);
                hx(0, 0, {ad[7:6], 1'b1, ad[4:0]}, wd);
                chk("mem write", {1'b1, cv[4:3], ad[4:0], wd}, got);
                hx(1, 0, {ad[7:6], 1'b1, ad[4:0]}, wd);
                chk("mem read", {1'b0, cv[4:3], ad[4:0], mdat(cv[4:3], ad[4:0])},
                    {got[15:8], rv});
            end
            $display("bus style %0d done", md);
        end
        // Six slow streams on the shared pins at both clock rates
        for (md = 0; md < 2; md = md + 1) begin
            serial_speed_select_reg_in <= md[0];
            half <= md ? 15 : 30;
            bits = {$random(seed), $random(seed)};
            @(posedge sys_clk_in);
            wt(0);
            switch_16x8_in <= 1'b1;
            for (i = 7; i >= 0; i = i - 1) begin
                for (k = 0; k < 6; k = k + 1) sbits[k] <= bits[8 * k + i];
                @(posedge sys_clk_in);
                wt(0);
            end
            wt(1);
            chk("serial", bits[47:0], serial_in_bytes_out);
            switch_16x8_in <= 1'b0;
            $display("serial speed %0d done", md);
        end
        complete_run;
    end
endmodule // cbi_host_port_tb
